// File: verilog/addr_gen_map.vh
// Constants of the indirect data address generator: modes, register map, field sizes.
`ifndef ADDR_GEN_MAP_VH
`define ADDR_GEN_MAP_VH

// Data width of pointers, index registers and ring limits.
`define AG_DATA_W          16
// Register port address width.
`define AG_ADDR_W          5

// Post-modification modes presented by the instruction decoder.
`define AG_MODE_W          3
`define AG_MODE_NONE       3'h0
`define AG_MODE_INC        3'h1
`define AG_MODE_DEC        3'h2
`define AG_MODE_INDEX      3'h3
`define AG_MODE_MODULO     3'h4
`define AG_MODE_BITREV     3'h5
`define AG_MODE_IMM        3'h6

// Register map, one 16-bit register per address.
`define AG_REG_PTR_BASE    5'h00
`define AG_REG_IDX_BASE    5'h08
`define AG_REG_X_LIMIT     5'h10
`define AG_REG_Y_LIMIT     5'h11
`define AG_REG_X_LAST      5'h12
`define AG_REG_Y_LAST      5'h13

// Reset values.
`define AG_PTR_RESET       16'h0000
`define AG_IDX_RESET       16'h0000
`define AG_LIMIT_RESET     16'h0001

`endif

// File: verilog/bit_mirror.v
// Mirrors a pointer word end to end to form a bit-reversed address.
`timescale 1ns/1ns
`include "addr_gen_map.vh"

module bit_mirror (
   input  wire [`AG_DATA_W-1:0] i_word,
   output wire [`AG_DATA_W-1:0] o_word
);

   genvar b;

   generate
      for (b = 0; b < `AG_DATA_W; b = b + 1) begin : g_bit
         assign o_word[b] = i_word[`AG_DATA_W-1-b];
      end
   endgenerate

endmodule

// File: verilog/ring_modulo_adder.v
// Modulo index addition confined to the low field of a pointer.
`timescale 1ns/1ns
`include "addr_gen_map.vh"

module ring_modulo_adder (
   input  wire [`AG_DATA_W-1:0] i_pointer,
   input  wire [`AG_DATA_W-1:0] i_index,
   input  wire [`AG_DATA_W-1:0] i_limit,
   output reg  [`AG_DATA_W-1:0] o_result
);

   reg        [`AG_DATA_W-1:0] low_mask;
   reg signed [`AG_DATA_W+1:0] low_sum;
   reg signed [`AG_DATA_W+1:0] limit_ext;
   reg signed [`AG_DATA_W+1:0] adjusted;
   integer                     i;

   always @* begin
      low_mask = i_limit;
      for (i = 1; i < `AG_DATA_W; i = i + 1) begin
         low_mask = low_mask | (low_mask >> 1);
      end
      limit_ext = $signed({2'b00, i_limit});
      low_sum = $signed({2'b00, i_pointer & low_mask}) +
                $signed({{2{i_index[`AG_DATA_W-1]}}, i_index});
      if (low_sum > limit_ext) begin
         adjusted = low_sum - limit_ext - 18'sh00001;
      end else if (low_sum < 18'sh00000) begin
         // A negative step wraps to the top of the ring, the mirror of the upward case.
         adjusted = low_sum + limit_ext + 18'sh00001;
      end else begin
         adjusted = low_sum;
      end
      o_result = (i_pointer & ~low_mask) | (adjusted[`AG_DATA_W-1:0] & low_mask);
   end

endmodule

// File: verilog/indirect_addr_gen.v
// Indirect data address generator for the X and Y data spaces with its register port.
//
// Summary of operation
// - Address is the selected pointer, unchanged except in bit-reverse mode.
// - Pointer modified only after its access.
// - Modified pointer used by the next instruction.
// - Loaded pointer valid from second following instruction.
// - Pointers 0-3 X space, 4-7 Y space.
// - No-change mode leaves pointer untouched.
// - Post-increment adds one after access.
// - Post-decrement subtracts one after access.
// - Index addition uses same-numbered index register.
// - Index is signed 16-bit two's complement.
// - Modulo uses X limit or Y limit.
// - Bit-reverse addresses mirrored, stores original plus index.
// - Immediate mode adds signed immediate after access.
// - Modulo adds to low field, wraps, keeps upper.
// - Ring spans upper-bit block, zero to limit.
// - Ring holds limit plus one entries.
// - Sixteen-bit pointers and indexes readable and writable.
// - Bit-reverse mirrors the whole pointer word.
`timescale 1ns/1ns
`include "addr_gen_map.vh"

module indirect_addr_gen (
   input  wire                  i_core_clk,
   input  wire                  i_resetn,
   // Register port.
   input  wire [`AG_ADDR_W-1:0] i_reg_addr,
   input  wire [`AG_DATA_W-1:0] i_reg_wdata,
   input  wire                  i_reg_wr,
   input  wire                  i_reg_rd,
   output wire [`AG_DATA_W-1:0] o_reg_rdata,
   // X space request from the instruction decoder.
   input  wire                  i_x_req,
   input  wire [1:0]            i_x_sel,
   input  wire [`AG_MODE_W-1:0] i_x_mode,
   // Y space request from the instruction decoder.
   input  wire                  i_y_req,
   input  wire [1:0]            i_y_sel,
   input  wire [`AG_MODE_W-1:0] i_y_mode,
   // Immediate operand shared by both spaces.
   input  wire [`AG_DATA_W-1:0] i_imm,
   // Addresses to the data memories.
   output wire [`AG_DATA_W-1:0] o_x_addr,
   output wire                  o_x_valid,
   output wire [`AG_DATA_W-1:0] o_y_addr,
   output wire                  o_y_valid
);

   // Reset synchroniser.
   reg                   rst_meta_q;
   reg                   rst_sync_q;
   wire                  rst_n;

   // Architectural registers.
   reg  [`AG_DATA_W-1:0] data_pointer_q [0:7];
   reg  [`AG_DATA_W-1:0] pointer_index_q [0:7];
   reg  [`AG_DATA_W-1:0] x_ring_limit_q;
   reg  [`AG_DATA_W-1:0] y_ring_limit_q;

   // Staged pointer load from the register port.
   reg                   load_pend_q;
   reg  [2:0]            load_sel_q;
   reg  [`AG_DATA_W-1:0] load_data_q;

   // Per-space request view and arithmetic.
   wire                  sp_req    [0:1];
   wire [1:0]            sp_sel    [0:1];
   wire [`AG_MODE_W-1:0] sp_mode   [0:1];
   wire [`AG_DATA_W-1:0] sp_ptr    [0:1];
   wire [`AG_DATA_W-1:0] sp_idx    [0:1];
   wire [`AG_DATA_W-1:0] sp_limit  [0:1];
   wire [`AG_DATA_W-1:0] sp_mirror [0:1];
   wire [`AG_DATA_W-1:0] sp_ring   [0:1];
   reg  [`AG_DATA_W-1:0] sp_next   [0:1];
   reg  [`AG_DATA_W-1:0] sp_addr   [0:1];
   reg                   sp_modify [0:1];
   wire [2:0]            sp_num    [0:1];
   wire [`AG_DATA_W-1:0] sp_idx_sum [0:1];
   wire [`AG_DATA_W-1:0] sp_imm_sum [0:1];

   // Output registers.
   reg  [`AG_DATA_W-1:0] x_addr_q;
   reg                   x_valid_q;
   reg  [`AG_DATA_W-1:0] y_addr_q;
   reg                   y_valid_q;
   reg  [`AG_DATA_W-1:0] rdata_q;
   reg  [`AG_DATA_W-1:0] rdata_d;

   wire                  wr_ptr;
   wire                  wr_idx;
   wire                  hit_ptr;
   wire                  hit_idx;
   wire                  hit_x_limit;
   wire                  hit_y_limit;

   // Register map decode; the pointer and index banks are eight-word aligned groups.
   localparam [`AG_ADDR_W-1:0] ptr_base = `AG_REG_PTR_BASE;
   localparam [`AG_ADDR_W-1:0] idx_base = `AG_REG_IDX_BASE;
   localparam [1:0]            ptr_grp  = ptr_base[4:3];
   localparam [1:0]            idx_grp  = idx_base[4:3];

   genvar s;
   genvar p;

   // Reset asserts at once but releases only on the second edge, so no flop leaves
   // reset on an edge where the release is still settling.
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_n = rst_sync_q;

   assign hit_ptr     = (i_reg_addr[4:3] == ptr_grp);
   assign hit_idx     = (i_reg_addr[4:3] == idx_grp);
   assign hit_x_limit = (i_reg_addr == `AG_REG_X_LIMIT);
   assign hit_y_limit = (i_reg_addr == `AG_REG_Y_LIMIT);
   // Writes to the last-address words fall through every decode, so those stay read-only.
   assign wr_ptr      = i_reg_wr && hit_ptr;
   assign wr_idx      = i_reg_wr && hit_idx;

   // pointer load staged
   // A pointer write is held for one cycle before it lands, so the instruction right
   // after the write still sees the old pointer; software must not count on it sooner.
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_pend_q <= 1'b0;
         load_sel_q  <= 3'h0;
         load_data_q <= `AG_PTR_RESET;
      end else begin
         load_pend_q <= wr_ptr;
         if (wr_ptr) begin
            load_sel_q  <= i_reg_addr[2:0];
            load_data_q <= i_reg_wdata;
         end
      end
   end

   assign sp_req[0]  = i_x_req;
   assign sp_sel[0]  = i_x_sel;
   assign sp_mode[0] = i_x_mode;
   assign sp_req[1]  = i_y_req;
   assign sp_sel[1]  = i_y_sel;
   assign sp_mode[1] = i_y_mode;

   assign sp_limit[0] = x_ring_limit_q;
   assign sp_limit[1] = y_ring_limit_q;

   generate
      for (s = 0; s < 2; s = s + 1) begin : g_space
         // four pointers per space
         // The Y unit reaches pointers four to seven only, so no select value crosses over.
         assign sp_num[s] = {(s == 1), sp_sel[s]};
         assign sp_ptr[s] = data_pointer_q[sp_num[s]];
         assign sp_idx[s] = pointer_index_q[sp_num[s]];
         // signed index add
         // A sixteen-bit sum wraps exactly as a signed index would, so no extension is needed.
         // One adder serves both index addition and the bit-reverse mode.
         assign sp_idx_sum[s] = sp_ptr[s] + sp_idx[s];
         // immediate add
         // The immediate is shared; the decoder never asks for it in both spaces at once.
         assign sp_imm_sum[s] = sp_ptr[s] + i_imm;

         bit_mirror u_mirror (
            .i_word (sp_ptr[s]),
            .o_word (sp_mirror[s])
         );

         ring_modulo_adder u_ring (
            .i_pointer (sp_ptr[s]),
            .i_index   (sp_idx[s]),
            .i_limit   (sp_limit[s]),
            .o_result  (sp_ring[s])
         );

         always @* begin
            sp_addr[s]   = sp_ptr[s];
            sp_next[s]   = sp_ptr[s];
            sp_modify[s] = 1'b1;
            case (sp_mode[s])
               `AG_MODE_NONE: begin
                  sp_modify[s] = 1'b0;
               end
               `AG_MODE_INC: begin
                  sp_next[s] = sp_ptr[s] + 16'h0001;
               end
               `AG_MODE_DEC: begin
                  sp_next[s] = sp_ptr[s] - 16'h0001;
               end
               `AG_MODE_INDEX: begin
                  sp_next[s] = sp_idx_sum[s];
               end
               `AG_MODE_MODULO: begin
                  // ring step
                  // Indexes larger than the limit are not caught; the step then stays inside
                  // the ring field but is no longer a true modulo.
                  sp_next[s] = sp_ring[s];
               end
               `AG_MODE_BITREV: begin
                  // mirrored address only
                  // The mirror feeds the address alone; the stored pointer grows from the
                  // unreversed value, which is what an FFT address sequence wants.
                  sp_addr[s] = sp_mirror[s];
                  sp_next[s] = sp_idx_sum[s];
               end
               `AG_MODE_IMM: begin
                  sp_next[s] = sp_imm_sum[s];
               end
               default: begin
                  sp_modify[s] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   // visible next cycle
   // The address leaves on the same edge that writes the new pointer, so the access
   // always carries the prior value and the next request already reads the new one.
   generate
      for (p = 0; p < 8; p = p + 1) begin : g_ptr
         always @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               data_pointer_q[p] <= `AG_PTR_RESET;
            end else if (load_pend_q && (load_sel_q == p)) begin
               // A landing load overrides a post-modification of the same pointer.
               data_pointer_q[p] <= load_data_q;
            end else if (sp_req[p/4] && sp_modify[p/4] && (sp_num[p/4] == p)) begin
               data_pointer_q[p] <= sp_next[p/4];
            end
         end

         always @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               pointer_index_q[p] <= `AG_IDX_RESET;
            end else if (wr_idx && (i_reg_addr[2:0] == p)) begin
               pointer_index_q[p] <= i_reg_wdata;
            end
         end
      end
   endgenerate

   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         x_ring_limit_q <= `AG_LIMIT_RESET;
         y_ring_limit_q <= `AG_LIMIT_RESET;
      end else begin
         if (i_reg_wr && hit_x_limit) begin
            x_ring_limit_q <= i_reg_wdata;
         end
         if (i_reg_wr && hit_y_limit) begin
            y_ring_limit_q <= i_reg_wdata;
         end
      end
   end

   // Address outputs hold their last value between accesses.
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         x_addr_q  <= 16'h0000;
         x_valid_q <= 1'b0;
      end else begin
         x_valid_q <= sp_req[0];
         if (sp_req[0]) begin
            x_addr_q <= sp_addr[0];
         end
      end
   end

   // separate Y unit
   // The Y address register is never touched by an X access, and the reverse.
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         y_addr_q  <= 16'h0000;
         y_valid_q <= 1'b0;
      end else begin
         y_valid_q <= sp_req[1];
         if (sp_req[1]) begin
            y_addr_q <= sp_addr[1];
         end
      end
   end

   always @* begin
      rdata_d = 16'h0000;
      if (hit_ptr) begin
         rdata_d = data_pointer_q[i_reg_addr[2:0]];
      end else if (hit_idx) begin
         rdata_d = pointer_index_q[i_reg_addr[2:0]];
      end else begin
         case (i_reg_addr)
            `AG_REG_X_LIMIT: rdata_d = x_ring_limit_q;
            `AG_REG_Y_LIMIT: rdata_d = y_ring_limit_q;
            `AG_REG_X_LAST:  rdata_d = x_addr_q;
            `AG_REG_Y_LAST:  rdata_d = y_addr_q;
            default:         rdata_d = 16'h0000;
         endcase
      end
   end

   // Read data stand for exactly the cycle after the strobe and are zero otherwise.
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else if (i_reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_x_addr    = x_addr_q;
   assign o_x_valid   = x_valid_q;
   assign o_y_addr    = y_addr_q;
   assign o_y_valid   = y_valid_q;

endmodule

// File: tb/addr_gen_chk.sv
// Port-level assertions for the indirect data address generator.
`timescale 1ns/1ns
`include "addr_gen_map.vh"
module addr_gen_chk (
   input wire logic        i_core_clk,
   input wire logic        i_resetn,
   input wire logic [4:0]  i_reg_addr,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [15:0] o_reg_rdata,
   input wire logic        i_x_req,
   input wire logic [1:0]  i_x_sel,
   input wire logic [2:0]  i_x_mode,
   input wire logic        i_y_req,
   input wire logic [1:0]  i_y_sel,
   input wire logic [2:0]  i_y_mode,
   input wire logic [15:0] o_x_addr,
   input wire logic        o_x_valid,
   input wire logic [15:0] o_y_addr,
   input wire logic        o_y_valid
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   x_valid_a:
      assert property (i_x_req |=> o_x_valid) else $error("X access gave no valid");
   x_quiet_a:
      assert property (!i_x_req |=> !o_x_valid) else $error("X valid without a request");
   y_valid_a:
      assert property (i_y_req |=> o_y_valid) else $error("Y access gave no valid");
   x_addr_hold_a:
      assert property (!i_x_req |=> $stable(o_x_addr)) else $error("X address moved while idle");
   x_inc_step_a:
      assert property ((!$past(i_reg_wr) && !i_reg_wr && i_x_req && i_x_mode == `AG_MODE_INC)
         ##1 (i_x_req && i_x_sel == $past(i_x_sel)) |=> o_x_addr == $past(o_x_addr) + 16'h0001)
         else $error("X increment step wrong");
   x_none_keep_a:
      assert property ((!$past(i_reg_wr) && !i_reg_wr && i_x_req && i_x_mode == `AG_MODE_NONE)
         ##1 (i_x_req && i_x_sel == $past(i_x_sel)) |=> $stable(o_x_addr))
         else $error("X pointer changed in no-change mode");
   y_dec_step_a:
      assert property ((!$past(i_reg_wr) && !i_reg_wr && i_y_req && i_y_mode == `AG_MODE_DEC)
         ##1 (i_y_req && i_y_sel == $past(i_y_sel)) |=> o_y_addr == $past(o_y_addr) - 16'h0001)
         else $error("Y decrement step wrong");
   rd_idle_a:
      assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000) else $error("Read data without read");
   unmapped_rd_a:
      assert property (i_reg_rd && i_reg_addr > 5'h13 |=> o_reg_rdata == 16'h0000)
         else $error("Unmapped read not zero");

   cover property (i_x_req && i_x_mode == `AG_MODE_MODULO);
   cover property (i_y_req && i_y_mode == `AG_MODE_BITREV);
   cover property (i_x_req && i_x_mode == `AG_MODE_IMM);
endmodule

bind indirect_addr_gen addr_gen_chk i_addr_gen_chk (.i_core_clk, .i_resetn, .i_reg_addr,
   .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_x_req, .i_x_sel, .i_x_mode, .i_y_req, .i_y_sel,
   .i_y_mode, .o_x_addr, .o_x_valid, .o_y_addr, .o_y_valid);

// File: tb/data_mem_model.sv
// Data memory stand-in that shows the address each space is accessed at.
`timescale 1ns/1ns
module data_mem_model (
   input  wire logic [15:0] i_x_addr,
   input  wire logic        i_x_valid,
   input  wire logic [15:0] i_y_addr,
   input  wire logic        i_y_valid,
   output logic [15:0]      o_x_seen,
   output logic [15:0]      o_y_seen
);
   // each space decodes only its own unit.
   // An unselected memory shows the inverse so a missing strobe never matches.
   assign o_x_seen = i_x_valid ? i_x_addr : ~i_x_addr;
   assign o_y_seen = i_y_valid ? i_y_addr : ~i_y_addr;
endmodule

// File: tb/tb_dsp_indirect_address_generator.sv
// Self-checking bench for the indirect data address generator.
`timescale 1ns/1ns
`include "addr_gen_map.vh"
module tb_dsp_indirect_address_generator;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        xr = 1'b0;
   logic        yr = 1'b0;
   logic [4:0]  ra = 5'h00;
   logic [15:0] wd = 16'h0000;
   logic [15:0] imm = 16'h0000;
   logic [1:0]  sel = 2'h0;
   logic [2:0]  mode = 3'h0;
   wire  [15:0] rdata;
   wire  [15:0] xa;
   wire  [15:0] ya;
   wire  [15:0] x_seen;
   wire  [15:0] y_seen;
   wire         xv;
   wire         yv;
   int          n_errors = 0;
   int          tests_run = 0;
   int          cycles = 0;

   indirect_addr_gen i_indirect_addr_gen (.i_core_clk(clk), .i_resetn(rstn), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_x_req(xr),
      .i_x_sel(sel), .i_x_mode(mode), .i_y_req(yr), .i_y_sel(sel), .i_y_mode(mode),
      .i_imm(imm), .o_x_addr(xa), .o_x_valid(xv), .o_y_addr(ya), .o_y_valid(yv));
   data_mem_model i_data_mem_model (.i_x_addr(xa), .i_x_valid(xv), .i_y_addr(ya),
      .i_y_valid(yv), .o_x_seen(x_seen), .o_y_seen(y_seen));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check("read", rdata, exp);
   endtask

   // Two back-to-back accesses: the chosen mode, then a no-change look at the result.
   task automatic b2b(input logic y, input logic [1:0] s, input logic [2:0] m,
                      input logic [15:0] e1, input logic [15:0] e2);
      @(posedge clk);
      xr <= !y;
      yr <= y;
      sel <= s;
      mode <= m;
      @(posedge clk);
      mode <= `AG_MODE_NONE;
      #1 check("access", y ? y_seen : x_seen, e1);
      check("other space", {15'h0000, y ? xv : yv}, 16'h0000);
      @(posedge clk);
      xr <= 1'b0;
      yr <= 1'b0;
      #1 check("next", y ? y_seen : x_seen, e2);
   endtask

   task automatic t_reset;
      rreg(`AG_REG_PTR_BASE, `AG_PTR_RESET);
      rreg(5'h0F, `AG_IDX_RESET);
      rreg(`AG_REG_Y_LIMIT, `AG_LIMIT_RESET);
      rreg(5'h1F, 16'h0000);
   endtask

   task automatic t_load;
      wreg(5'h02, 16'h1234);
      xr <= 1'b1;
      sel <= 2'h2;
      mode <= `AG_MODE_NONE;
      @(posedge clk);
      #1 check("old", x_seen, 16'h0000);
      @(posedge clk);
      xr <= 1'b0;
      #1 check("new", x_seen, 16'h1234);
      rreg(5'h02, 16'h1234);
   endtask

   task automatic t_modes;
      logic [2:0]  m [6] = '{`AG_MODE_INC, `AG_MODE_DEC, `AG_MODE_NONE, `AG_MODE_INDEX,
                             `AG_MODE_IMM, 3'h7};
      logic [15:0] e [7] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h0000,
                             16'h0000};
      wreg(5'h09, 16'h8000);
      wreg(5'h08, 16'h0005);
      wreg(5'h01, 16'hFFFF);
      imm <= 16'h8001;
      for (int i = 0; i < 6; i++) begin
         b2b(1'b0, 2'h1, m[i], e[i], e[i+1]);
      end
   endtask

   task automatic t_bitrev;
      wreg(5'h0D, 16'h0002);
      wreg(5'h05, 16'h0001);
      b2b(1'b1, 2'h1, `AG_MODE_BITREV, 16'h8000, 16'h0003);
      b2b(1'b1, 2'h1, `AG_MODE_DEC, 16'h0003, 16'h0002);
   endtask

   task automatic t_modulo;
      logic [15:0] e [5] = '{16'h0010, 16'h0013, 16'h0016, 16'h0019, 16'h0011};
      wreg(`AG_REG_X_LIMIT, 16'h000A);
      wreg(5'h08, 16'h0003);
      wreg(5'h00, 16'h0010);
      for (int i = 0; i < 4; i++) begin
         b2b(1'b0, 2'h0, `AG_MODE_MODULO, e[i], e[i+1]);
      end
      // A negative index steps below the ring start and wraps to its upper part.
      wreg(5'h08, 16'hFFFD);
      b2b(1'b0, 2'h0, `AG_MODE_MODULO, 16'h0011, 16'h0019);
      wreg(`AG_REG_Y_LIMIT, 16'h0007);
      wreg(5'h0C, 16'h0001);
      wreg(5'h04, 16'h1237);
      b2b(1'b1, 2'h0, `AG_MODE_MODULO, 16'h1237, 16'h1230);
      // The last-address words are read-only, so this write must leave no trace.
      wreg(`AG_REG_X_LAST, 16'h5A5A);
      rreg(`AG_REG_X_LAST, 16'h0019);
      rreg(`AG_REG_Y_LAST, 16'h1230);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         summarize();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_load();
      t_modes();
      t_bitrev();
      t_modulo();
      summarize();
   end
endmodule
